// ==== inc/rme_pkg.sv ====
// rme_pkg: offsets, field positions, reset values and codes shared by
// the mode and equalizer register bank and its helper modules.
// assumes: compiled before every file under hw/.
package rme_pkg;
  // register sub-addresses
  localparam logic [7:0] RME_GEN_OFS = 8'h0A;
  localparam logic [7:0] RME_EQ01_OFS = 8'h10;
  localparam logic [7:0] RME_EQ23_OFS = 8'h11;
  localparam logic [7:0] RME_SNOOP_OFS = 8'h12;
  localparam logic [7:0] RME_FIRST_OFS = 8'h00;
  // reset values
  localparam logic [7:0] RME_GEN_RST = 8'h01;
  localparam logic [7:0] RME_EQ_RST = 8'h00;
  localparam logic [7:0] RME_SNOOP_RST = 8'h00;
  // general register fields
  localparam int RME_GEN_BITS = 6;
  localparam int RME_SWAP_BIT = 5;
  localparam int RME_EQOVR_BIT = 4;
  localparam int RME_HPFORCE_BIT = 3;
  localparam int RME_FLIP_BIT = 2;
  localparam int RME_CFG1_BIT = 1;
  // snooped state register fields
  localparam int RME_PWR_LSB = 5;
  localparam int RME_CNT_LSB = 0;
  // lane configuration codes
  localparam logic [1:0] RME_CFG_OFF = 2'h0;
  localparam logic [1:0] RME_CFG_USB = 2'h1;
  localparam logic [1:0] RME_CFG_DP4 = 2'h2;
  localparam logic [1:0] RME_CFG_DP2USB = 2'h3;
  // snooped link addresses and values
  localparam logic [19:0] RME_AUX_PWR_ADDR = 20'h00600;
  localparam logic [19:0] RME_AUX_CNT_ADDR = 20'h00101;
  localparam logic [1:0] RME_PWR_ON = 2'h1;
  localparam logic [4:0] RME_LC_1 = 5'h01;
  localparam logic [4:0] RME_LC_2 = 5'h02;
  localparam logic [4:0] RME_LC_4 = 5'h04;
  // serial target defaults
  localparam logic [6:0] RME_DEV_ADDR_DEF = 7'h44;
  localparam logic [3:0] RME_BITS_BYTE = 4'h8;
  localparam logic [3:0] RME_BITS_LAST = 4'h7;
  // serial engine states and byte kinds
  typedef enum logic [2:0] {
    RME_IDLE, RME_RX, RME_ACK, RME_TX, RME_TACK
  } rme_i2c_e;
  typedef enum logic [1:0] {RME_K_ADDR, RME_K_SUB, RME_K_DATA} rme_kind_e;
  // strap level to equalizer code
  function automatic logic [3:0] rme_strap_eq(input logic [1:0] s);
    return {s, 2'h0};
  endfunction
endpackage

// ==== hw/rme_sync.sv ====
// rme_sync: two flip-flop synchroniser for a bundle of pin levels.
// assumes: each bit is an independent level; no bus coherence needed.
module rme_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // pins and synchronised levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rme_sync_s;
  rme_sync_s q, d;

  // first stage feeds only the second stage
  always_comb begin
    d = q;
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.s2;
endmodule // rme_sync

// ==== hw/rme_lane_gate.sv ====
// rme_lane_gate: decodes lane configuration and snooped link state into
// per-lane display enables and the usb link enable.
// assumes: inputs come from flops on core_clk; caller registers outputs.
module rme_lane_gate
  import rme_pkg::*;
(
  // configuration
  input wire logic [1:0] lane_cfg,
  input wire logic snoop_disable,
  input wire logic [3:0] dp_lane_off,
  // snooped state
  input wire logic [1:0] snoop_pwr,
  input wire logic [4:0] snoop_cnt,
  // decoded enables
  output logic [3:0] dp_en,
  output logic usb_en
);
  logic [3:0] allow;
  logic [3:0] snooped;

  // configuration bounds the lanes; snoop or lane-off bits pick within
  always_comb begin
    unique case (lane_cfg)
      RME_CFG_DP4: allow = 4'hF;
      RME_CFG_DP2USB: allow = 4'h3;
      default: allow = 4'h0;
    endcase
    usb_en = (lane_cfg == RME_CFG_USB) || (lane_cfg == RME_CFG_DP2USB);
    snooped = 4'h0;
    if (snoop_pwr == RME_PWR_ON) begin
      if (snoop_cnt == RME_LC_1) snooped = 4'h1;
      else if (snoop_cnt == RME_LC_2) snooped = 4'h3;
      else if (snoop_cnt == RME_LC_4) snooped = 4'hF;
    end
    dp_en = allow & (snoop_disable ? ~dp_lane_off : snooped);
  end
endmodule // rme_lane_gate

// ==== hw/rme_regbank.sv ====
// rme_regbank: mode and equalizer register bank of the redriving switch,
// reached over a two-wire serial target with byte sub-addressing.
// assumes: scl/sda and hotplug/strap pins are asynchronous; snoop
// strobes, lane-off bits and snoop-disable come from core_clk logic.
//
// What this block does
// R01: general register 0x0A, reset 01, top reserved
// R02: lane configuration code decodes usb and display lanes
// R03: swap bit exchanges the two hotplug pin locations
// R04: override bit picks registers over equalizer straps
// R05: force bit drives internal hotplug high
// R06: read/write orientation flip select at bit 2
// R07: register 0x10 holds lane 1 and 0 equalizers
// R08: register 0x11 holds lane 3 and 2 equalizers
// R09: straps update equalizers unless software override set
// R10: capture power-state snoop into 0x12 bits 6:5
// R11: snooped power state gates display lanes when enabled
// R12: capture lane-count snoop into 0x12 bits 4:0
// R13: snoop disabled: lanes follow lane-off bits
// R14: config bit1 falling clears both snooped fields
// R15: register 0x12 resets zero, writes ignored
// R16: snooping enabled while snoop-disable bit is zero
// R17: sub-address first; bare read starts at 00h
// R18: only writable fields take written data
module rme_regbank
  import rme_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = RME_DEV_ADDR_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // serial register port
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  // hotplug and strap pins
  input wire logic hotplug_input_pin,
  input wire logic hotplug_alt_pin,
  input wire logic [1:0] dp_equalizer_straps,
  // link write snoop
  input wire logic aux_wr_valid,
  input wire logic [19:0] aux_wr_addr,
  input wire logic [7:0] aux_wr_data,
  // lane control from the neighbouring register
  input wire logic [3:0] dp_lane_off,
  input wire logic aux_snoop_disable,
  // mode outputs
  output logic [1:0] lane_configuration_select,
  output logic orientation_flip_select,
  output logic hotplug_pin_swap,
  output logic hotplug_force_high,
  output logic hotplug_internal,
  output logic equalizer_register_override,
  // equalizer outputs
  output logic [3:0] dp_lane0_equalizer,
  output logic [3:0] dp_lane1_equalizer,
  output logic [3:0] dp_lane2_equalizer,
  output logic [3:0] dp_lane3_equalizer,
  // lane enables
  output logic [3:0] dp_lane_en,
  output logic usb_link_en
);
  typedef struct packed {
    // serial engine
    rme_i2c_e st;
    rme_kind_e kind;
    logic rw;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic sub_set;
    logic oe;
    logic mack;
    logic scl_prev;
    logic sda_prev;
    // registers
    logic [RME_GEN_BITS-1:0] gen;
    logic [7:0] eq01;
    logic [7:0] eq23;
    logic [1:0] pwr;
    logic [4:0] cnt;
    // registered outputs
    logic hp_int;
    logic [3:0] dp_en;
    logic usb_en;
  } rme_state_s;

  rme_state_s q, d;
  logic [5:0] pins_sync;
  logic s_scl, s_sda, s_hpa, s_hpb;
  logic [1:0] s_strap;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0] rd_byte;
  logic wr_en;
  logic pwr_hit, cnt_hit;
  logic [3:0] strap_eq;
  logic [3:0] gate_en;
  logic gate_usb;

  // every pin passes two flops before any logic reads it
  rme_sync #(.W(6)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in({scl_pin, sda_pin_in, hotplug_input_pin, hotplug_alt_pin,
               dp_equalizer_straps}),
    .sync_out(pins_sync)
  );
  assign {s_scl, s_sda, s_hpa, s_hpb, s_strap} = pins_sync;

  // bus edges and framing conditions from the synchronised levels
  assign scl_rise = s_scl & ~q.scl_prev;
  assign scl_fall = ~s_scl & q.scl_prev;
  assign start_cond = s_scl & q.scl_prev & q.sda_prev & ~s_sda;
  assign stop_cond = s_scl & q.scl_prev & ~q.sda_prev & s_sda;

  // snoop address decode
  assign pwr_hit = aux_wr_valid && (aux_wr_addr == RME_AUX_PWR_ADDR);
  assign cnt_hit = aux_wr_valid && (aux_wr_addr == RME_AUX_CNT_ADDR);
  assign strap_eq = rme_strap_eq(s_strap);

  // read data; unmapped offsets and reserved bits read zero
  always_comb begin
    unique case (q.ptr)
      RME_GEN_OFS: rd_byte = {2'h0, q.gen}; // [R01]
      RME_EQ01_OFS: rd_byte = q.eq01;
      RME_EQ23_OFS: rd_byte = q.eq23;
      RME_SNOOP_OFS: rd_byte = {1'b0, q.pwr, q.cnt}; // [R15]
      default: rd_byte = 8'h00;
    endcase
  end

  // lane enables from configuration and snooped state
  rme_lane_gate u_gate (
    .lane_cfg(q.gen[1:0]),
    .snoop_disable(aux_snoop_disable),
    .dp_lane_off(dp_lane_off),
    .snoop_pwr(q.pwr),
    .snoop_cnt(q.cnt),
    .dp_en(gate_en),
    .usb_en(gate_usb)
  );

  // next state: serial engine, register updates, output flops
  always_comb begin
    d = q;
    wr_en = 1'b0;
    d.scl_prev = s_scl;
    d.sda_prev = s_sda;
    // a stop ends any transfer; a start restarts even mid-byte
    if (stop_cond) begin
      d.st = RME_IDLE;
      d.oe = 1'b0;
      if (q.rw) d.sub_set = 1'b0; // next bare read starts at 00h [R17]
    end else if (start_cond) begin
      d.st = RME_RX;
      d.kind = RME_K_ADDR;
      d.bits = 4'h0;
      d.oe = 1'b0;
    end else begin
      unique case (q.st)
        RME_IDLE: begin
        end
        RME_RX: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], s_sda};
            d.bits = q.bits + 4'h1;
          end else if (scl_fall && q.bits == RME_BITS_BYTE) begin
            unique case (q.kind)
              RME_K_ADDR: begin
                if (q.sh[7:1] == DEV_ADDR) begin
                  d.rw = q.sh[0];
                  d.oe = 1'b1;
                  d.st = RME_ACK;
                  // read without a prior sub-address begins at 00h
                  if (q.sh[0] && !q.sub_set) d.ptr = RME_FIRST_OFS; // [R17]
                end else begin
                  d.st = RME_IDLE;
                end
              end
              RME_K_SUB: begin
                d.ptr = q.sh; // first byte after address is sub-address [R17]
                d.sub_set = 1'b1;
                d.oe = 1'b1;
                d.st = RME_ACK;
              end
              default: begin
                wr_en = 1'b1;
                d.ptr = q.ptr + 8'h01;
                d.oe = 1'b1;
                d.st = RME_ACK;
              end
            endcase
          end
        end
        RME_ACK: begin
          if (scl_fall) begin
            d.bits = 4'h0;
            if (q.rw) begin
              d.tx = rd_byte;
              d.ptr = q.ptr + 8'h01;
              d.oe = ~rd_byte[7];
              d.st = RME_TX;
            end else begin
              d.oe = 1'b0;
              d.st = RME_RX;
              d.kind = (q.kind == RME_K_ADDR) ? RME_K_SUB : RME_K_DATA;
            end
          end
        end
        RME_TX: begin
          // msb first; each falling edge presents the next bit
          if (scl_fall) begin
            if (q.bits == RME_BITS_LAST) begin
              d.oe = 1'b0;
              d.st = RME_TACK;
            end else begin
              d.tx = {q.tx[6:0], 1'b1};
              d.oe = ~q.tx[6];
              d.bits = q.bits + 4'h1;
            end
          end
        end
        RME_TACK: begin
          if (scl_rise) begin
            d.mack = ~s_sda;
          end else if (scl_fall) begin
            d.bits = 4'h0;
            if (q.mack) begin
              d.tx = rd_byte; // successive registers byte by byte [R17]
              d.ptr = q.ptr + 8'h01;
              d.oe = ~rd_byte[7];
              d.st = RME_TX;
            end else begin
              d.st = RME_IDLE;
            end
          end
        end
      endcase
    end

    // general register: reserved top bits never stored [R01] [R18]
    if (wr_en && q.ptr == RME_GEN_OFS) begin
      d.gen = q.sh[RME_GEN_BITS-1:0]; // [R02] [R06]
    end

    // equalizers follow straps until software takes over [R04] [R09]
    if (q.gen[RME_EQOVR_BIT]) begin
      if (wr_en && q.ptr == RME_EQ01_OFS) d.eq01 = q.sh; // [R07]
      if (wr_en && q.ptr == RME_EQ23_OFS) d.eq23 = q.sh; // [R08]
    end else begin
      d.eq01 = {strap_eq, strap_eq};
      d.eq23 = {strap_eq, strap_eq};
    end

    // config bit1 falling clears snoop; a same-cycle capture wins
    if (q.gen[RME_CFG1_BIT] && !d.gen[RME_CFG1_BIT]) begin
      d.pwr = 2'h0; // [R14]
      d.cnt = 5'h00; // [R14]
    end
    // snoop captures; bus writes to 0x12 never reach these [R15]
    if (pwr_hit) d.pwr = aux_wr_data[1:0]; // [R10]
    if (cnt_hit) d.cnt = aux_wr_data[4:0]; // [R12]

    // hotplug: force beats swap, swap picks the alternate pin
    d.hp_int = q.gen[RME_HPFORCE_BIT] | // [R05]
               (q.gen[RME_SWAP_BIT] ? s_hpb : s_hpa); // [R03]
    // snoop enabled by a zero disable bit [R11] [R13] [R16]
    d.dp_en = gate_en;
    d.usb_en = gate_usb; // [R02]
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.gen <= RME_GEN_RST[RME_GEN_BITS-1:0];
      q.eq01 <= RME_EQ_RST;
      q.eq23 <= RME_EQ_RST;
      q.pwr <= RME_SNOOP_RST[6:5];
      q.cnt <= RME_SNOOP_RST[4:0];
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops; open-drain data only ever pulls low
  assign sda_pin_out = 1'b0;
  assign sda_pin_oe = q.oe;
  assign lane_configuration_select = q.gen[1:0];
  assign orientation_flip_select = q.gen[RME_FLIP_BIT];
  assign hotplug_pin_swap = q.gen[RME_SWAP_BIT];
  assign hotplug_force_high = q.gen[RME_HPFORCE_BIT];
  assign hotplug_internal = q.hp_int;
  assign equalizer_register_override = q.gen[RME_EQOVR_BIT];
  assign dp_lane0_equalizer = q.eq01[3:0];
  assign dp_lane1_equalizer = q.eq01[7:4];
  assign dp_lane2_equalizer = q.eq23[3:0];
  assign dp_lane3_equalizer = q.eq23[7:4];
  assign dp_lane_en = q.dp_en;
  assign usb_link_en = q.usb_en;

  // checks on the bank
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_gen_reserved;
    (q.ptr == RME_GEN_OFS) |-> (rd_byte[7:6] == 2'h0);
  endproperty
  a_gen_reserved: assert property (p_gen_reserved) // [R01]
    else $error("general register reserved bits not zero");

  property p_cfg_off;
    (q.gen[1:0] == RME_CFG_OFF) |=> (dp_lane_en == 4'h0 && !usb_link_en);
  endproperty
  a_cfg_off: assert property (p_cfg_off) // [R02]
    else $error("lanes enabled while configuration is off");

  property p_force_hp;
    q.gen[RME_HPFORCE_BIT] |=> hotplug_internal;
  endproperty
  a_force_hp: assert property (p_force_hp) // [R05]
    else $error("forced hotplug not high");

  property p_eq_hold;
    (q.gen[RME_EQOVR_BIT] && !wr_en) |=> $stable({q.eq01, q.eq23});
  endproperty
  a_eq_hold: assert property (p_eq_hold) // [R09]
    else $error("equalizer changed under override without a write");

  property p_pwr_cap;
    pwr_hit |=> (q.pwr == $past(aux_wr_data[1:0]));
  endproperty
  a_pwr_cap: assert property (p_pwr_cap) // [R10]
    else $error("power state snoop not captured");

  property p_cnt_cap;
    cnt_hit |=> (q.cnt == $past(aux_wr_data[4:0]));
  endproperty
  a_cnt_cap: assert property (p_cnt_cap) // [R12]
    else $error("lane count snoop not captured");

  property p_snoop_off;
    (aux_snoop_disable && q.gen[1:0] == RME_CFG_DP4)
      |=> (dp_lane_en == ~$past(dp_lane_off));
  endproperty
  a_snoop_off: assert property (p_snoop_off) // [R13]
    else $error("lanes ignore lane-off bits while snoop disabled");

  property p_cfg_clear;
    ($fell(q.gen[RME_CFG1_BIT]) && !$past(pwr_hit) && !$past(cnt_hit))
      |-> (q.pwr == 2'h0 && q.cnt == 5'h00);
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) // [R14]
    else $error("snoop fields not cleared on config bit1 fall");

  property p_snoop_ro;
    (wr_en && !pwr_hit && !cnt_hit && !(q.gen[RME_CFG1_BIT] &&
      !d.gen[RME_CFG1_BIT])) |=> $stable({q.pwr, q.cnt});
  endproperty
  a_snoop_ro: assert property (p_snoop_ro) // [R15]
    else $error("bus write changed snooped fields");
endmodule // rme_regbank

// ==== bench/rme_i2c_host.sv ====
// rme_i2c_host: two-wire host model that programs the register bank.
// assumes: sda_line is the resolved open-drain level with a pull-up;
// the target never stretches scl.
module rme_i2c_host #(
  parameter logic [6:0] TARGET = 7'h44
) (
  // pacing clock
  input wire logic core_clk,
  // bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  // quarter bit in clocks; the target needs at least 4 per phase
  localparam int Q = 5;
  logic [6:0] target = TARGET;
  logic acked;
  // idle bus: both lines left to their pull-ups
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    acked = 1'b0;
  end
  // move just after a rising edge so changes never race the sampler
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic put_bit(input logic b);
    sda_pull = ~b;
    tick(Q);
    scl = 1'b1;
    tick(2 * Q);
    scl = 1'b0;
    tick(Q);
  endtask
  // data is sampled in mid-high, long after the target's 3-4 clock lag
  task automatic get_bit(output logic b);
    sda_pull = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    b = sda_line;
    tick(Q);
    scl = 1'b0;
    tick(Q);
  endtask
  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_pull = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_pull = 1'b1;
    tick(Q);
    scl = 1'b0;
    tick(Q);
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_pull = 1'b0;
    tick(2 * Q);
  endtask
  task automatic send(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    acked = acked & ~a;
  endtask
  // the sub-address always leads; n = 0 only moves the pointer
  task automatic wr(input logic [7:0] sub, input logic [15:0] d,
                    input int n);
    acked = 1'b1;
    start();
    send({target, 1'b0});
    send(sub);
    for (int i = 0; i < n; i++) send(d[8 * (n - 1 - i) +: 8]);
    stop();
  endtask
  // read n bytes, the last four kept in q; the last byte is refused
  task automatic rd(input logic [7:0] sub, input logic use_sub,
                    input int n, output logic [31:0] q);
    logic b;
    q = '0;
    if (use_sub) wr(sub, 16'h0000, 0);
    acked = 1'b1;
    start();
    send({target, 1'b1});
    for (int i = 0; i < n; i++) begin
      for (int j = 0; j < 8; j++) begin
        get_bit(b);
        q = {q[30:0], b};
      end
      put_bit(i == n - 1);
    end
    stop();
  endtask
endmodule // rme_i2c_host

// ==== bench/redriver_mode_eq_registers_test.sv ====
// redriver_mode_eq_registers_test: register bank driven by the host
// model, snoop strobes and pins from the bench.
// assumes: straps sit at 2'b10 apart from one short 2'b01 step, so strap-driven equalizers read 8.
module redriver_mode_eq_registers_test;
  timeunit 1ns;
  timeprecision 100ps;
  import rme_pkg::*;
  localparam logic [6:0] TGT = 7'h44;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic scl, sda_pull, sda_line, sda_pin_out, sda_pin_oe;
  logic hp_def, hp_alt, aux_wr_valid, snoop_dis;
  logic [1:0] straps, cfg;
  logic [19:0] aux_wr_addr;
  logic [7:0] aux_wr_data;
  logic [3:0] lane_off, eq0, eq1, eq2, eq3, dp_lane_en;
  logic flip, swap, force_hi, hp_int, eq_ovr, usb_link_en;
  logic [31:0] q;
  int bad_count = 0;
  int n_tests = 0;
  // open drain: either party pulling wins, else the pull-up
  assign sda_line = ~(sda_pull | sda_pin_oe);
  always #5 core_clk = ~core_clk;
  rme_i2c_host #(.TARGET(TGT)) u_rme_i2c_host (
    .core_clk(core_clk), .sda_line(sda_line), .scl(scl),
    .sda_pull(sda_pull));
  rme_regbank #(.DEV_ADDR(TGT)) u_rme_regbank (
    .core_clk(core_clk), .resetn(resetn), .scl_pin(scl),
    .sda_pin_in(sda_line), .sda_pin_out(sda_pin_out),
    .sda_pin_oe(sda_pin_oe), .hotplug_input_pin(hp_def),
    .hotplug_alt_pin(hp_alt), .dp_equalizer_straps(straps),
    .aux_wr_valid(aux_wr_valid), .aux_wr_addr(aux_wr_addr),
    .aux_wr_data(aux_wr_data), .dp_lane_off(lane_off),
    .aux_snoop_disable(snoop_dis), .lane_configuration_select(cfg),
    .orientation_flip_select(flip), .hotplug_pin_swap(swap),
    .hotplug_force_high(force_hi), .hotplug_internal(hp_int),
    .equalizer_register_override(eq_ovr), .dp_lane0_equalizer(eq0),
    .dp_lane1_equalizer(eq1), .dp_lane2_equalizer(eq2),
    .dp_lane3_equalizer(eq3), .dp_lane_en(dp_lane_en),
    .usb_link_en(usb_link_en));
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rchk(input logic [7:0] sub, input logic [7:0] exp);
    logic [31:0] r;
    u_rme_i2c_host.rd(sub, 1'b1, 1, r);
    check($sformatf("register %h", sub), r[7:0], exp);
  endtask
  task automatic wgen(input logic [7:0] v);
    u_rme_i2c_host.wr(RME_GEN_OFS, {8'h00, v}, 1);
    step(2);
  endtask
  // one-cycle snoop strobe, settled two edges later
  task automatic aux(input logic [19:0] a, input logic [7:0] d);
    aux_wr_addr = a;
    aux_wr_data = d;
    aux_wr_valid = 1'b1;
    step(1);
    aux_wr_valid = 1'b0;
    step(2);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // a hung bus transfer would otherwise stall the run for ever
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    hp_def = 1'b0;
    hp_alt = 1'b1;
    straps = 2'b10;
    aux_wr_valid = 1'b0;
    aux_wr_addr = '0;
    aux_wr_data = '0;
    lane_off = 4'h0;
    snoop_dis = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 resetn = 1'b1;
    step(8);
    // reset state and strap-driven equalizers
    check("lane config", 8'(cfg), 8'h01);
    check("usb enable", 8'(usb_link_en), 8'h01);
    check("lane0 eq", 8'(eq0), 8'h08);
    check("hotplug", 8'(hp_int), 8'h00);
    check("sda value", 8'(sda_pin_out), 8'h00);
    rchk(RME_GEN_OFS, 8'h01);
    rchk(RME_EQ01_OFS, 8'h88);
    rchk(RME_EQ23_OFS, 8'h88);
    rchk(RME_SNOOP_OFS, 8'h00);
    $display("test reset done");
    // reserved bits drop writes; every mode bit reaches its output
    // both hotplug pins low, so only the force bit can raise hotplug
    hp_alt = 1'b0;
    wgen(8'hFF);
    rchk(RME_GEN_OFS, 8'h3F);
    check("mode bits", {2'b00, swap, eq_ovr, force_hi, flip, cfg},
          8'h3F);
    check("hotplug", 8'(hp_int), 8'h01);
    hp_alt = 1'b1;
    snoop_dis = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wgen({6'h08, c[1:0]});
      step(4);
      check("usb enable", 8'(usb_link_en), 8'(c[0]));
      check("lane enable", 8'(dp_lane_en),
            c == 2 ? 8'h0F : c == 3 ? 8'h03 : 8'h00);
      check("hotplug", 8'(hp_int), 8'(hp_alt));
    end
    $display("test general done");
    // software equalizers win only under override
    wgen(8'h12);
    u_rme_i2c_host.wr(RME_EQ01_OFS, 16'hA53C, 2);
    step(2);
    check("lanes 1 0 eq", {eq1, eq0}, 8'hA5);
    check("lanes 3 2 eq", {eq3, eq2}, 8'h3C);
    rchk(RME_EQ23_OFS, 8'h3C);
    wgen(8'h02);
    step(6);
    rchk(RME_EQ01_OFS, 8'h88);
    u_rme_i2c_host.wr(RME_EQ01_OFS, 16'h0055, 1);
    rchk(RME_EQ01_OFS, 8'h88);
    check("lane3 eq", 8'(eq3), 8'h08);
    // a strap change must reach the fields while override is clear
    straps = 2'b01;
    step(4);
    check("lane2 eq", 8'(eq2), 8'h04);
    straps = 2'b10;
    $display("test equalizer done");
    // snooped power state and lane count gate the display lanes
    snoop_dis = 1'b0;
    lane_off = 4'b0101;
    aux(RME_AUX_PWR_ADDR, 8'h01);
    aux(RME_AUX_CNT_ADDR, 8'h02);
    check("lane enable", 8'(dp_lane_en), 8'h03);
    rchk(RME_SNOOP_OFS, 8'h22);
    u_rme_i2c_host.wr(RME_SNOOP_OFS, 16'h00FF, 1);
    rchk(RME_SNOOP_OFS, 8'h22);
    // upper data bits fall outside the five-bit count field
    aux(RME_AUX_CNT_ADDR, 8'hE1);
    check("lane enable", 8'(dp_lane_en), 8'h01);
    aux(RME_AUX_CNT_ADDR, 8'h04);
    check("lane enable", 8'(dp_lane_en), 8'h0F);
    aux(RME_AUX_PWR_ADDR, 8'h02);
    check("lane enable", 8'(dp_lane_en), 8'h00);
    snoop_dis = 1'b1;
    step(3);
    check("lane enable", 8'(dp_lane_en), 8'h0A);
    rchk(RME_SNOOP_OFS, 8'h44);
    wgen(8'h01);
    rchk(RME_SNOOP_OFS, 8'h00);
    $display("test snoop done");
    // a bare read after a finished read starts at 00h
    u_rme_i2c_host.rd(8'h00, 1'b0, 11, q);
    check("bare read", q[7:0], 8'h01);
    check("bare read", q[15:8], 8'h00);
    // a foreign target address is neither acknowledged nor obeyed
    u_rme_i2c_host.target = 7'h45;
    wgen(8'h03);
    check("acknowledge", 8'(u_rme_i2c_host.acked), 8'h00);
    u_rme_i2c_host.target = TGT;
    rchk(RME_GEN_OFS, 8'h01);
    check("acknowledge", 8'(u_rme_i2c_host.acked), 8'h01);
    $display("test serial done");
    test_done();
  end
endmodule // redriver_mode_eq_registers_test
